// ===== logic/crosspoint_regs.vh
// constants for the b channel crosspoint multiplexer
// assumes byte-wide register port, indices used as addresses
`ifndef CROSSPOINT_REGS_VH
`define CROSSPOINT_REGS_VH

// ****************************************
// register map
// ****************************************
`define ADDR_PATH_ONE 8'h41
`define ADDR_PATH_TWO 8'h42
`define ADDR_PATH_THREE 8'h43
`define ADDR_IRQ_ORDER 8'h44
`define ADDR_IRQ_STATUS 8'h45
`define ADDR_IRQ_MASK 8'h46
`define ADDR_HOST_DATA 8'h47

// ****************************************
// fields
// ****************************************
`define FLD_PORT1_HI 7
`define FLD_PORT1_LO 4
`define FLD_PORT2_HI 3
`define FLD_PORT2_LO 0
`define BIT_HOST_IRQ_EN 3
`define BIT_REV_FIRST 4
`define BIT_REV_SECOND 5
`define ORDER_WRITE_MASK 8'h38
`define BIT_STATUS_HOST 4
`define STATUS_WRITE_MASK 8'h10

// ****************************************
// channel codes
// ****************************************
`define CH_NONE 4'h0
`define CH_LINE_B1 4'h1
`define CH_LINE_B2 4'h2
`define CH_CODEC 4'h3
`define CH_HOST_FIRST 4'h4
`define CH_HOST_SECOND 4'h5
`define CH_PERI_FIRST 4'h6
`define CH_PERI_THIRD 4'h8

// ****************************************
// timing
// ****************************************
`define FRAME_NS 125000
`define CLK_NS 10
`define FRAME_CYCLES (`FRAME_NS / `CLK_NS)
`define RESET_SEL 8'h00

`endif

// ===== logic/bit_order_swap.v
// optional bit reversal of one byte
// assumes combinational use inside the crosspoint
`timescale 1ns/100ps
`default_nettype none

module bit_order_swap (
    input wire [7:0] din,
    input wire reverse,
    output wire [7:0] dout
);
    wire [7:0] flipped;
    genvar i;

    // ****************************************
    // mirror per bit
    // ****************************************
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign flipped[i] = din[7 - i];
        end
    endgenerate

    // lsb-first host view is the mirrored byte
    assign dout = reverse ? flipped : din;
endmodule

`default_nettype wire

// ===== logic/frame_timer.v
// frame boundary pulse generator
// assumes mclk free-running, count given in cycles
`timescale 1ns/100ps
`default_nettype none

module frame_timer #(
    parameter integer CYCLES = 12500
) (
    input wire mclk,
    input wire rst,
    output reg tick
);
    reg [31:0] count_q;

    // ****************************************
    // counter
    // ****************************************
    // one pulse every CYCLES clocks
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= 32'h00000000;
            tick <= 1'b0;
        end else if (count_q == CYCLES - 1) begin
            count_q <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 32'h00000001;
            tick <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== logic/b_channel_crosspoint_mux.v
// b channel crosspoint: routes eight logical 64 kbit/s channels, byte per frame
// assumes all channel bytes are on mclk; frame tick is internal
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "crosspoint_regs.vh"

module b_channel_crosspoint_mux #(
    parameter integer FRAME_CYCLES = `FRAME_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire [7:0] line_b1_in,
    input wire [7:0] line_b2_in,
    input wire [7:0] codec_in,
    input wire [7:0] peri_first_in,
    input wire [7:0] peri_second_in,
    input wire [7:0] peri_third_in,
    output reg [7:0] line_b1_out,
    output reg [7:0] line_b2_out,
    output reg [7:0] codec_out,
    output reg [7:0] peri_first_out,
    output reg [7:0] peri_second_out,
    output reg [7:0] peri_third_out,
    output reg [7:0] out_valid,
    output wire frame_tick,
    output wire irq
);
    // ****************************************
    // registers
    // ****************************************
    // selections as software last wrote them
    reg [7:0] path_one_q;
    reg [7:0] path_two_q;
    reg [7:0] path_three_q;
    reg [7:0] order_q;
    reg [7:0] status_q;
    reg [7:0] mask_q;

    // selections in force this frame; a write mid-frame never splits a byte
    reg [7:0] act_one_q;
    reg [7:0] act_two_q;
    reg [7:0] act_three_q;

    // host slot buffers in software bit order
    reg [7:0] host_tx_q;
    reg [7:0] host_tx2_q;
    reg [7:0] host_rx_q;
    reg [7:0] host_rx2_q;

    // routed bytes bound for the host slots, line bit order
    reg [7:0] rx_d;
    reg [7:0] rx2_d;

    // host data port alternates between the two slots
    reg host_wr_sel_q;

    // frame pulse and mirrored host views
    wire tick;
    wire [7:0] host_first_tx_w;
    wire [7:0] host_second_tx_w;
    wire [7:0] host_first_rx_w;
    wire [7:0] host_second_rx_w;

    // the same pulse paces the far-side units
    assign frame_tick = tick;

    frame_timer #(.CYCLES(FRAME_CYCLES)) u_timer (
        .mclk(mclk),
        .rst(rst),
        .tick(tick)
    );

    // ****************************************
    // host channel bit order
    // ****************************************
    // software holds msb-first bytes; line view mirrors on request
    bit_order_swap u_tx_first (
        .din(host_tx_q),
        .reverse(order_q[`BIT_REV_FIRST]),
        .dout(host_first_tx_w)
    );
    bit_order_swap u_tx_second (
        .din(host_tx2_q),
        .reverse(order_q[`BIT_REV_SECOND]),
        .dout(host_second_tx_w)
    );
    // received bytes are mirrored back before software reads them
    bit_order_swap u_rx_first (
        .din(rx_d),
        .reverse(order_q[`BIT_REV_FIRST]),
        .dout(host_first_rx_w)
    );
    bit_order_swap u_rx_second (
        .din(rx2_d),
        .reverse(order_q[`BIT_REV_SECOND]),
        .dout(host_second_rx_w)
    );

    // ****************************************
    // source lookup
    // ****************************************
    // undefined codes give no source
    function [8:0] src_of;
        input [3:0] code;
        input [7:0] b1, b2, cd, h1, h2, p1, p2, p3;
        begin
            case (code)
                4'h1: src_of = {1'b1, b1};
                4'h2: src_of = {1'b1, b2};
                4'h3: src_of = {1'b1, cd};
                4'h4: src_of = {1'b1, h1};
                4'h5: src_of = {1'b1, h2};
                4'h6: src_of = {1'b1, p1};
                4'h7: src_of = {1'b1, p2};
                4'h8: src_of = {1'b1, p3};
                default: src_of = 9'h000;
            endcase
        end
    endfunction

    // ****************************************
    // crosspoint
    // ****************************************
    // later registers overwrite earlier, so path three wins
    reg [7:0] dest [1:8];
    reg [8:1] dvalid;
    reg [8:0] s;
    reg [7:0] act;
    integer p, c;
    always @* begin
        // unrouted channels carry zero and are flagged empty
        for (c = 1; c <= 8; c = c + 1) begin
            dest[c] = 8'h00;
        end
        dvalid = 8'h00;
        s = 9'h000;
        act = 8'h00;
        for (p = 0; p < 3; p = p + 1) begin
            act = (p == 0) ? act_one_q : (p == 1) ? act_two_q : act_three_q;
            // port one receives port two
            s = src_of(act[`FLD_PORT2_HI:`FLD_PORT2_LO], line_b1_in, line_b2_in, codec_in,
                host_first_tx_w, host_second_tx_w, peri_first_in, peri_second_in, peri_third_in);
            for (c = 1; c <= 8; c = c + 1) begin
                if (s[8] && act[`FLD_PORT1_HI:`FLD_PORT1_LO] == c) begin
                    dest[c] = s[7:0];
                    dvalid[c] = 1'b1;
                end
            end
            // port two receives port one
            s = src_of(act[`FLD_PORT1_HI:`FLD_PORT1_LO], line_b1_in, line_b2_in, codec_in,
                host_first_tx_w, host_second_tx_w, peri_first_in, peri_second_in, peri_third_in);
            for (c = 1; c <= 8; c = c + 1) begin
                if (s[8] && act[`FLD_PORT2_HI:`FLD_PORT2_LO] == c) begin
                    dest[c] = s[7:0];
                    dvalid[c] = 1'b1;
                end
            end
        end
        // host slots pick up their byte from the same table
        rx_d = dest[4];
        rx2_d = dest[5];
    end

    // ****************************************
    // frame transfer
    // ****************************************
    // one byte each way per 125 us frame; settings latched at boundary
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_one_q <= `RESET_SEL;
            act_two_q <= `RESET_SEL;
            act_three_q <= `RESET_SEL;
            line_b1_out <= 8'h00;
            line_b2_out <= 8'h00;
            codec_out <= 8'h00;
            peri_first_out <= 8'h00;
            peri_second_out <= 8'h00;
            peri_third_out <= 8'h00;
            host_rx_q <= 8'h00;
            host_rx2_q <= 8'h00;
            out_valid <= 8'h00;
        end else if (tick) begin
            act_one_q <= path_one_q;
            act_two_q <= path_two_q;
            act_three_q <= path_three_q;
            line_b1_out <= dest[1];
            line_b2_out <= dest[2];
            codec_out <= dest[3];
            peri_first_out <= dest[6];
            peri_second_out <= dest[7];
            peri_third_out <= dest[8];
            // a host slot keeps its last byte when nothing feeds it
            if (dvalid[4]) begin
                host_rx_q <= host_first_rx_w;
            end
            if (dvalid[5]) begin
                host_rx2_q <= host_second_rx_w;
            end
            // flags tell the far side which slots carry a byte
            out_valid <= dvalid;
        end
    end

    // ****************************************
    // register writes and status
    // ****************************************
    // host byte arrival sets status; set beats write-one clear
    wire host_event = tick && (dvalid[4] || dvalid[5]);
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            path_one_q <= `RESET_SEL;
            path_two_q <= `RESET_SEL;
            path_three_q <= `RESET_SEL;
            order_q <= `RESET_SEL;
            status_q <= 8'h00;
            mask_q <= 8'h00;
            host_tx_q <= 8'h00;
            host_tx2_q <= 8'h00;
            host_wr_sel_q <= 1'b0;
        end else begin
            if (wr) begin
                if (addr == `ADDR_PATH_ONE) begin
                    path_one_q <= wdata;
                end else if (addr == `ADDR_PATH_TWO) begin
                    path_two_q <= wdata;
                end else if (addr == `ADDR_PATH_THREE) begin
                    path_three_q <= wdata;
                end else if (addr == `ADDR_IRQ_ORDER) begin
                    order_q <= wdata & `ORDER_WRITE_MASK;
                end else if (addr == `ADDR_IRQ_MASK) begin
                    // only the host byte bit exists in status and mask
                    mask_q <= wdata & `STATUS_WRITE_MASK;
                end else if (addr == `ADDR_HOST_DATA) begin
                    // alternate writes fill first then second host slot
                    if (host_wr_sel_q) begin
                        host_tx2_q <= wdata;
                    end else begin
                        host_tx_q <= wdata;
                    end
                    host_wr_sel_q <= ~host_wr_sel_q;
                end
            end
            // clear and set together: the set stays so no byte goes unnoticed
            if (wr && addr == `ADDR_IRQ_STATUS) begin
                status_q <= (status_q & ~(wdata & `STATUS_WRITE_MASK))
                    | {3'b000, host_event, 4'h0};
            end else if (host_event) begin
                status_q[`BIT_STATUS_HOST] <= 1'b1;
            end
        end
    end

    // enable bit and mask both gate the line
    assign irq = status_q[`BIT_STATUS_HOST] & order_q[`BIT_HOST_IRQ_EN] & mask_q[`BIT_STATUS_HOST];

    // ****************************************
    // read port
    // ****************************************
    // unmapped addresses read zero
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr == `ADDR_PATH_ONE) begin
                rdata <= path_one_q;
            end else if (addr == `ADDR_PATH_TWO) begin
                rdata <= path_two_q;
            end else if (addr == `ADDR_PATH_THREE) begin
                rdata <= path_three_q;
            end else if (addr == `ADDR_IRQ_ORDER) begin
                rdata <= order_q;
            end else if (addr == `ADDR_IRQ_STATUS) begin
                rdata <= status_q;
            end else if (addr == `ADDR_IRQ_MASK) begin
                rdata <= mask_q;
            end else if (addr == `ADDR_HOST_DATA) begin
                // the slot named by the write toggle is the one read back
                rdata <= host_wr_sel_q ? host_rx2_q : host_rx_q;
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            // idle cycles read zero so stale data never lingers on the bus
            rdata <= 8'h00;
        end
    end
endmodule

`default_nettype wire

// ===== tb/crosspoint_assertions.sv
// port checker for the crosspoint mux
// assumes bind from the bench top, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "crosspoint_regs.vh"

module crosspoint_checker #(
    parameter integer FRAME_CYCLES = 16
) (
    input wire mclk,
    input wire rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire [7:0] line_b1_out,
    input wire [7:0] codec_out,
    input wire [7:0] out_valid,
    input wire frame_tick,
    input wire irq
);
    // **********
    // shadows
    // **********
    reg [7:0] p1_q;
    reg [7:0] ord_q;
    reg msk_q;
    reg seen_q;
    reg [15:0] gap_q;
    wire gate = ord_q[3] & msk_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // software writes; a counter avoids a long repetition
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            p1_q <= 8'h00;
            ord_q <= 8'h00;
            msk_q <= 1'b0;
            seen_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            if (wr && addr == `ADDR_PATH_ONE) p1_q <= wdata;
            if (wr && addr == `ADDR_IRQ_ORDER) ord_q <= wdata;
            if (wr && addr == `ADDR_IRQ_MASK) msk_q <= wdata[4];
            seen_q <= seen_q | frame_tick;
            gap_q <= frame_tick ? 16'h0000 : gap_q + 16'h0001;
        end
    end

    // **********
    // properties
    // **********
    property p_read_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("rdata without read");
    property p_unmapped;
        $past(rd) && ($past(addr) < 8'h41 || $past(addr) > 8'h47) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_path_back;
        rd && addr == `ADDR_PATH_ONE |=> rdata == $past(p1_q);
    endproperty
    a_path_back: assert property (p_path_back) else $error("path one readback");
    property p_order_back;
        rd && addr == `ADDR_IRQ_ORDER |=> rdata == ($past(ord_q) & `ORDER_WRITE_MASK);
    endproperty
    a_order_back: assert property (p_order_back) else $error("control readback");
    property p_tick_gap;
        frame_tick && seen_q |-> gap_q == FRAME_CYCLES - 1;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("frame period");
    property p_tick_pulse;
        frame_tick |=> !frame_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    // outputs move only at the edge that acts on the tick
    property p_stand;
        !$past(frame_tick) |-> $stable(line_b1_out) && $stable(codec_out) && $stable(out_valid);
    endproperty
    a_stand: assert property (p_stand) else $error("byte changed mid frame");
    property p_irq_gate;
        !gate |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while gated");
endmodule
`default_nettype wire

// ===== tb/channel_far_side.sv
// far-side units: line, codec and peripheral slots
// assumes frame_tick from the mux; bytes change at each tick
`timescale 1ns/100ps
`default_nettype none

module channel_far_side (
    input wire mclk,
    input wire rst,
    input wire frame_tick,
    output var logic [3:0] fcnt,
    output wire [7:0] line_b1_in,
    output wire [7:0] line_b2_in,
    output wire [7:0] codec_in,
    output wire [7:0] peri_first_in,
    output wire [7:0] peri_second_in,
    output wire [7:0] peri_third_in
);
    // **********
    // one byte per unit per frame
    // **********
    // frame count in the low nibble, so a stale byte shows
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            fcnt <= 4'h0;
        end else if (frame_tick) begin
            fcnt <= fcnt + 4'h1;
        end
    end
    // source code in the high nibble
    assign line_b1_in = {4'h1, fcnt};
    assign line_b2_in = {4'h2, fcnt};
    assign codec_in = {4'h3, fcnt};
    assign peri_first_in = {4'h6, fcnt};
    assign peri_second_in = {4'h7, fcnt};
    assign peri_third_in = {4'h8, fcnt};
endmodule
`default_nettype wire

// ===== tb/tb_b_channel_crosspoint_mux.sv
// bench for the b channel crosspoint mux
// assumes the register header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "crosspoint_regs.vh"

module tb_b_channel_crosspoint_mux;
    localparam integer FC = 16;
    logic mclk, rst, wr, rd;
    logic [7:0] addr, wdata;
    wire [7:0] rdata, out_valid, line_b1_in, line_b2_in, codec_in;
    wire [7:0] peri_first_in, peri_second_in, peri_third_in, line_b1_out;
    wire [7:0] line_b2_out, codec_out, peri_first_out, peri_second_out, peri_third_out;
    wire [3:0] fcnt;
    wire frame_tick, irq;
    int checked = 0;
    int n_mismatch = 0;

    b_channel_crosspoint_mux #(.FRAME_CYCLES(FC)) uut (.mclk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .line_b1_in, .line_b2_in, .codec_in, .peri_first_in, .peri_second_in,
        .peri_third_in, .line_b1_out, .line_b2_out, .codec_out, .peri_first_out,
        .peri_second_out, .peri_third_out, .out_valid, .frame_tick, .irq);
    channel_far_side far (.mclk, .rst, .frame_tick, .fcnt, .line_b1_in, .line_b2_in,
        .codec_in, .peri_first_in, .peri_second_in, .peri_third_in);

    // **********
    // bus and compare helpers
    // **********
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // new routing needs a latching tick and a carrying tick
    task automatic frames(input int n);
        repeat (n) @(posedge mclk iff frame_tick);
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic clear_paths;
        for (int a = 1; a < 4; a++) wr_reg(8'h40 + a[7:0], 8'h00);
    endtask
    // byte sampled at the last tick, one frame count back
    function automatic logic [7:0] exp_byte(input logic [3:0] c);
        return {c, fcnt - 4'h1};
    endfunction
    function automatic logic [7:0] sel_out(input logic [3:0] c);
        case (c)
            4'h2: return line_b2_out;
            4'h3: return codec_out;
            4'h6: return peri_first_out;
            4'h7: return peri_second_out;
            default: return peri_third_out;
        endcase
    endfunction

    // **********
    // scenarios
    // **********
    task automatic s_regs;
        logic [7:0] d;
        for (int a = 8'h41; a <= 8'h44; a++) begin
            rd_reg(a[7:0], d);
            check("reset value", d, 8'h00);
        end
        rd_reg(8'h50, d);
        check("unmapped", d, 8'h00);
        wr_reg(`ADDR_IRQ_ORDER, 8'hFF);
        rd_reg(`ADDR_IRQ_ORDER, d);
        check("reserved", d, `ORDER_WRITE_MASK);
        wr_reg(`ADDR_IRQ_ORDER, 8'h00);
    endtask
    task automatic s_paths;
        logic [3:0] far_c [5] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'h8};
        foreach (far_c[i]) begin
            wr_reg(`ADDR_PATH_ONE, {`CH_LINE_B1, far_c[i]});
            frames(3);
            check("b1 in", line_b1_out, exp_byte(far_c[i]));
            check("far in", sel_out(far_c[i]), exp_byte(`CH_LINE_B1));
            check("valid", out_valid, 8'h01 | (8'h01 << (far_c[i] - 4'h1)));
        end
        frames(1);
        check("next frame", line_b1_out, exp_byte(`CH_LINE_B1 + 4'h7));
        clear_paths;
    endtask
    // three paths fight over the first peripheral slot
    task automatic s_prio;
        wr_reg(`ADDR_PATH_ONE, 8'h26);
        wr_reg(`ADDR_PATH_TWO, 8'h16);
        wr_reg(`ADDR_PATH_THREE, 8'h63);
        frames(3);
        check("b1 in", line_b1_out, exp_byte(4'h6));
        check("b2 in", line_b2_out, exp_byte(4'h6));
        check("codec in", codec_out, exp_byte(4'h3 + 4'h3));
        check("peri in", peri_first_out, exp_byte(`CH_CODEC));
        clear_paths;
    endtask
    // undefined codes beside a loopback
    task automatic s_odd;
        wr_reg(`ADDR_PATH_ONE, 8'h19);
        wr_reg(`ADDR_PATH_TWO, 8'hF2);
        wr_reg(`ADDR_PATH_THREE, 8'h33);
        frames(3);
        check("valid", out_valid, 8'h04);
        check("loop", codec_out, exp_byte(`CH_CODEC));
        clear_paths;
    endtask
    task automatic s_host;
        logic [7:0] d;
        logic [3:0] f;
        wr_reg(`ADDR_IRQ_MASK, 8'h10);
        wr_reg(`ADDR_IRQ_ORDER, 8'h30);
        wr_reg(`ADDR_PATH_ONE, 8'h14);
        wr_reg(`ADDR_PATH_TWO, 8'h25);
        wr_reg(`ADDR_HOST_DATA, 8'h01);
        wr_reg(`ADDR_HOST_DATA, 8'h02);
        frames(3);
        f = fcnt - 4'h1;
        check("irq off", {7'h00, irq}, 8'h00);
        check("first rev", line_b1_out, 8'h80);
        check("second rev", line_b2_out, 8'h40);
        check("host valid", out_valid, 8'h1B);
        rd_reg(`ADDR_IRQ_STATUS, d);
        check("status", d & 8'h10, 8'h10);
        // line byte {1, f} mirrored into the first host slot
        rd_reg(`ADDR_HOST_DATA, d);
        check("first rx rev", d, {f[0], f[1], f[2], f[3], 4'h8});
        wr_reg(`ADDR_IRQ_ORDER, 8'h38);
        @(posedge mclk);
        #1 check("irq on", {7'h00, irq}, 8'h01);
        frames(1);
        wr_reg(`ADDR_IRQ_MASK, 8'h00);
        @(posedge mclk);
        #1 check("irq masked", {7'h00, irq}, 8'h00);
        wr_reg(`ADDR_IRQ_MASK, 8'h10);
        rd_reg(`ADDR_IRQ_MASK, d);
        check("mask back", d, 8'h10);
        wr_reg(`ADDR_IRQ_STATUS, 8'h10);
        @(posedge mclk);
        #1 check("irq cleared", {7'h00, irq}, 8'h00);
        clear_paths;
    endtask

    task automatic tally_and_finish;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // clock, reset and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        s_regs;
        s_paths;
        s_prio;
        s_odd;
        s_host;
        tally_and_finish;
    end
    // the run needs about five hundred cycles
    initial begin
        repeat (8000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule

bind b_channel_crosspoint_mux crosspoint_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.mclk,
    .rst, .addr, .wdata, .wr, .rd, .rdata, .line_b1_out, .codec_out, .out_valid,
    .frame_tick, .irq);
`default_nettype wire
